// ===== hw/idc_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a fill level.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module idc_fifo #(
    parameter int unsigned W     = 35,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       in_valid,
    output logic                            in_ready,
    input  wire logic [W-1:0]               in_data,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic [W-1:0]                    out_data,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [$clog2(DEPTH+1)-1:0] FULL = ($clog2(DEPTH+1))'(DEPTH);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [$clog2(DEPTH+1)-1:0] cnt_q;
    wire push = in_valid && in_ready;
    wire pop  = out_valid && out_ready;

    assign in_ready  = (cnt_q != FULL);
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop)  rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end

    // Storage needs no reset; emptiness is tracked by the count
    always_ff @(posedge clk) begin
        if (push) mem_q[wr_q] <= in_data;
    end
endmodule
`default_nettype wire

// ===== hw/idc_iso_dma_regs.sv
// Isochronous DMA context registers: transmit descriptor pointers,
// receive context control with set/clear aliases, receive packet path.
// Assumes an AHB-Lite master and link-side streams on the same clock.
//
// Summary of operation
// - Each transmit context loads its first descriptor pointer and fetches it on run.
// - The transmit pointer reads back the value in use while active.
// - Eight read-only transmit pointers at 20Ch plus 16 bytes per context.
// - Four receive controls: set alias 400h, clear alias 404h, 32 bytes apart.
// - Run is changed only by software or by system or software reset.
// - Active shows while the receive context processes descriptors.
// - Pack option fills buffers back to back; otherwise one packet per buffer.
// - Multi-channel accepts every channel enabled in the channel mask.
// - Setting split-payload mode forces multi-channel and pack to zero.
// - Header option stores the 4-byte packet header with each packet.
// - With header kept, a trailer of status and cycle stamp ends each packet.
// - Without header option only the payload is stored.
// - A kept header is stored directly ahead of its payload.
// - Start-on-cycle waits for the match cycle value in a cycle start.
// - Start-on-cycle clears itself once the context is active.
`timescale 1ns/1ps
`default_nettype none
module idc_iso_dma_regs
    import idc_pkg::*;
#(
    parameter int unsigned BUFW  = idc_pkg::BUF_WORDS,
    parameter int unsigned DEPTH = idc_pkg::FIFO_DEPTH
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             tx_fetch_valid,
    input  wire logic        tx_fetch_ready,
    output logic      [31:0] tx_fetch_addr,
    output logic      [2:0]  tx_fetch_ctx,
    input  wire logic        tx_ptr_upd_valid,
    input  wire logic [2:0]  tx_ptr_upd_ctx,
    input  wire logic [31:0] tx_ptr_upd_value,
    input  wire logic        cyc_start_valid,
    input  wire logic [2:0]  cyc_seconds_low,
    input  wire logic [12:0] cyc_count,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic [31:0] rx_data,
    input  wire logic        rx_first,
    input  wire logic        rx_last,
    input  wire logic [15:0] rx_status,
    output logic             mem_valid,
    input  wire logic        mem_ready,
    output logic      [31:0] mem_data,
    output logic             mem_buf_end,
    output logic      [1:0]  mem_ctx,
    output logic      [3:0]  rx_active
);
    import idc_pkg::*;

    localparam int unsigned LW = $clog2(DEPTH+1);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic slot_hit(input logic [11:0] a, input logic [11:0] base,
                                      input int unsigned lg, input int unsigned cnt);
        logic [11:0] off;
        off = a - base;
        return (a >= base) && ((off & ((12'h1 << lg) - 12'h1)) == 12'h0) && ((off >> lg) < 12'(cnt));
    endfunction

    function automatic logic [2:0] first_one(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) if (v[i]) r = 3'(i);
        return r;
    endfunction

    // ----------------------------------------
    // AHB-Lite slave: one wait state per transfer
    // ----------------------------------------
    logic        pend_q;
    logic        write_q;
    logic [11:0] addr_q;
    logic        srst_q;

    wire acc_wr = pend_q && write_q;
    wire tx_hit   = slot_hit(addr_q, TX_PTR_BASE,   TX_STRIDE_LG, NTX);
    wire txs_hit  = slot_hit(addr_q, TX_START_BASE, TX_STRIDE_LG, NTX);
    wire rxs_hit  = slot_hit(addr_q, RX_SET_BASE,   RX_STRIDE_LG, NRX);
    wire rxc_hit  = slot_hit(addr_q, RX_CLR_BASE,   RX_STRIDE_LG, NRX);
    wire rxm_hit  = slot_hit(addr_q, RX_MATCH_BASE, RX_STRIDE_LG, NRX);
    wire [2:0] tx_idx = 3'((addr_q - TX_PTR_BASE) >> TX_STRIDE_LG);
    wire [2:0] txs_idx = 3'((addr_q - TX_START_BASE) >> TX_STRIDE_LG);
    wire [1:0] rx_idx = 2'(addr_q >> RX_STRIDE_LG);
    wire run_wr   = acc_wr && (addr_q == TX_RUN_OFF);
    wire srst_wr  = acc_wr && (addr_q == SOFT_RST_OFF) && hwdata[0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q    <= 1'b0;
            write_q   <= 1'b0;
            addr_q    <= 12'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (pend_q) begin
            pend_q    <= 1'b0;
            hreadyout <= 1'b1;
        end else if (hsel && htrans[1] && hready) begin
            pend_q    <= 1'b1;
            write_q   <= hwrite;
            addr_q    <= haddr[11:0];
            hreadyout <= 1'b0;
        end
    end

    // Software reset is a one-cycle pulse, so it cannot lock the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) srst_q <= 1'b0;
        else          srst_q <= srst_wr;
    end

    // ----------------------------------------
    // Transmit contexts
    // ----------------------------------------
    logic [31:0] tx_ptr_q   [NTX];
    logic [31:0] tx_start_q [NTX];
    logic [7:0]  tx_run_q;
    logic [7:0]  tx_pend_q;
    wire  [7:0]  tx_run_d  = run_wr ? hwdata[7:0] : tx_run_q;
    wire  [7:0]  tx_rise   = tx_run_d & ~tx_run_q;
    wire  [2:0]  tx_pick   = first_one(tx_pend_q);
    wire         tx_issue  = (|tx_pend_q) && (!tx_fetch_valid || tx_fetch_ready);

    generate
        for (genvar t = 0; t < NTX; t++) begin : g_tx
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    tx_ptr_q[t]   <= TX_PTR_RST;
                    tx_start_q[t] <= REG_RST;
                end else begin
                    if (acc_wr && txs_hit && txs_idx == 3'(t)) tx_start_q[t] <= hwdata;
                    if (tx_rise[t])
                        tx_ptr_q[t] <= tx_start_q[t];
                    else if (tx_ptr_upd_valid && tx_ptr_upd_ctx == 3'(t) && tx_run_q[t])
                        tx_ptr_q[t] <= tx_ptr_upd_value;
                end
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_run_q       <= 8'h00;
            tx_pend_q      <= 8'h00;
            tx_fetch_valid <= 1'b0;
            tx_fetch_addr  <= 32'h0;
            tx_fetch_ctx   <= 3'h0;
        end else if (srst_q) begin
            tx_run_q       <= 8'h00;
            tx_pend_q      <= 8'h00;
            tx_fetch_valid <= 1'b0;
        end else begin
            tx_run_q  <= tx_run_d;
            // New request wins over the grant of the same context
            tx_pend_q <= ((tx_pend_q & ~(tx_issue ? (8'h01 << tx_pick) : 8'h00)) | tx_rise) & tx_run_d;
            if (tx_issue) begin
                tx_fetch_valid <= 1'b1;
                tx_fetch_addr  <= tx_ptr_q[tx_pick];
                tx_fetch_ctx   <= tx_pick;
            end else if (tx_fetch_ready) begin
                tx_fetch_valid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Receive context control and match
    // ----------------------------------------
    logic [31:0] rx_ctl_q   [NRX];
    logic [31:0] rx_match_q [NRX];
    logic [63:0] chmask_q;
    logic [3:0]  rx_run;
    logic [3:0]  rx_hdr;
    logic [3:0]  rx_pack;
    logic [3:0]  rx_take;
    logic [15:0] stamp_q;
    wire  [5:0]  chan = rx_data[CHAN_HI:CHAN_LO];

    generate
        for (genvar r = 0; r < NRX; r++) begin : g_rx
            logic [31:0] sw;
            logic [31:0] nx;
            logic        act_d;
            wire wr_set = acc_wr && rxs_hit && rx_idx == 2'(r);
            wire wr_clr = acc_wr && rxc_hit && rx_idx == 2'(r);
            wire cyc_hit = cyc_start_valid &&
                           cyc_count == rx_match_q[r][MATCH_CYC_HI:MATCH_CYC_LO];
            always_comb begin
                sw = rx_ctl_q[r];
                if (wr_set) sw = rx_ctl_q[r] | (hwdata & RX_SW_MASK);
                if (wr_clr) sw = rx_ctl_q[r] & ~(hwdata & RX_SW_MASK);
                // Split mode is frozen while the context runs
                if (rx_ctl_q[r][BIT_RUN] || rx_ctl_q[r][BIT_ACTIVE]) sw[BIT_SPLIT] = rx_ctl_q[r][BIT_SPLIT];
                if (sw[BIT_SPLIT]) begin
                    sw[BIT_PACK]  = 1'b0;
                    sw[BIT_MULTI] = 1'b0;
                end
                act_d = sw[BIT_RUN] && (rx_ctl_q[r][BIT_ACTIVE] || !sw[BIT_CYC] || cyc_hit);
                nx = sw;
                nx[BIT_ACTIVE] = act_d;
                nx[BIT_CYC]    = sw[BIT_CYC] && !act_d;
            end
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    rx_ctl_q[r]   <= RX_CTL_RST;
                    rx_match_q[r] <= REG_RST;
                end else begin
                    rx_ctl_q[r] <= srst_q ? RX_CTL_RST : nx;
                    if (acc_wr && rxm_hit && rx_idx == 2'(r)) rx_match_q[r] <= hwdata & RX_MATCH_MASK;
                end
            end
            assign rx_run[r]  = rx_ctl_q[r][BIT_RUN];
            assign rx_hdr[r]  = rx_ctl_q[r][BIT_HDR];
            assign rx_pack[r] = rx_ctl_q[r][BIT_PACK];
            assign rx_take[r] = rx_ctl_q[r][BIT_ACTIVE] &&
                (rx_ctl_q[r][BIT_MULTI] ? chmask_q[chan] : rx_match_q[r][5:0] == chan);
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chmask_q  <= 64'h0;
            stamp_q   <= 16'h0;
            rx_active <= 4'h0;
        end else begin
            if (acc_wr && addr_q == CHMASK_HI_OFF) chmask_q[63:32] <= hwdata;
            if (acc_wr && addr_q == CHMASK_LO_OFF) chmask_q[31:0]  <= hwdata;
            if (cyc_start_valid) stamp_q <= {cyc_seconds_low, cyc_count};
            for (int i = 0; i < NRX; i++) rx_active[i] <= rx_ctl_q[i][BIT_ACTIVE];
        end
    end

    // ----------------------------------------
    // Register read
    // ----------------------------------------
    wire [31:0] rd_word =
        tx_hit  ? tx_ptr_q[tx_idx] :
        txs_hit ? tx_start_q[txs_idx] :
        (rxs_hit || rxc_hit) ? rx_ctl_q[rx_idx] :
        rxm_hit ? rx_match_q[rx_idx] :
        (addr_q == TX_RUN_OFF)    ? {24'h0, tx_run_q} :
        (addr_q == CHMASK_HI_OFF) ? chmask_q[63:32] :
        (addr_q == CHMASK_LO_OFF) ? chmask_q[31:0] : 32'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)                hrdata <= 32'h0;
        else if (pend_q && !write_q) hrdata <= rd_word;
    end

    // ----------------------------------------
    // Receive packet path into the FIFO
    // ----------------------------------------
    // Buffer fill count is shared: contexts interleaving mid-buffer
    // see one running count, acceptable since packets do not interleave.
    idc_rx_state_e state_q;
    idc_rx_state_e state_d;
    logic [1:0]  ctx_q;
    logic        ok_q;
    logic [15:0] status_q;
    logic [$clog2(BUFW+1)-1:0] wcnt_q;
    logic [LW-1:0] fifo_level;
    logic          fifo_in_ready;

    wire       accept  = rx_valid && rx_ready;
    wire [1:0] pick    = 2'(first_one({4'h0, rx_take}));
    wire       hdr_sel = rx_hdr[pick];
    wire       keep    = ok_q && rx_hdr[ctx_q];
    logic      push_v;
    logic [31:0] push_word;
    logic      pkt_end;

    always_comb begin
        state_d   = state_q;
        push_v    = 1'b0;
        push_word = rx_data;
        pkt_end   = 1'b0;
        case (state_q)
            IDC_RX_IDLE: if (accept && rx_first) begin
                push_v  = (|rx_take) && hdr_sel;
                state_d = rx_last ? (push_v ? IDC_RX_TRAIL : IDC_RX_IDLE) : IDC_RX_PAY;
            end
            IDC_RX_PAY: if (accept) begin
                push_v  = ok_q;
                pkt_end = rx_last && !keep;
                if (rx_last) state_d = keep ? IDC_RX_TRAIL : IDC_RX_IDLE;
            end
            IDC_RX_TRAIL: begin
                push_v    = fifo_in_ready;
                push_word = {status_q, stamp_q};
                pkt_end   = 1'b1;
                if (fifo_in_ready) state_d = IDC_RX_IDLE;
            end
            default: state_d = IDC_RX_IDLE;
        endcase
    end

    wire [1:0] push_ctx = (state_q == IDC_RX_IDLE) ? pick : ctx_q;
    wire push_end = (wcnt_q == ($clog2(BUFW+1))'(BUFW-1)) || (pkt_end && !rx_pack[push_ctx]);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q  <= IDC_RX_IDLE;
            ctx_q    <= 2'h0;
            ok_q     <= 1'b0;
            status_q <= 16'h0;
            wcnt_q   <= '0;
            rx_ready <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == IDC_RX_IDLE && accept && rx_first) begin
                ctx_q <= pick;
                ok_q  <= |rx_take;
            end
            if (accept && rx_last) status_q <= rx_status;
            if (push_v) wcnt_q <= push_end ? '0 : wcnt_q + 1'b1;
            // Two free slots keep the one-cycle ready lag safe
            rx_ready <= (fifo_level <= LW'(DEPTH-2)) && (state_d != IDC_RX_TRAIL);
        end
    end

    idc_fifo #(.W(35), .DEPTH(DEPTH)) u_fifo (
        .clk       (hclk),
        .rst_n     (hresetn),
        .in_valid  (push_v),
        .in_ready  (fifo_in_ready),
        .in_data   ({push_ctx, push_end, push_word}),
        .out_valid (mem_valid),
        .out_ready (mem_ready),
        .out_data  ({mem_ctx, mem_buf_end, mem_data}),
        .level     (fifo_level)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_TX_FIRST_PTR: assert property ($rose(tx_run_q[0]) |-> tx_ptr_q[0] == $past(tx_start_q[0]))
        else $error("tx pointer not loaded on run");
    AST_TX_FETCH: assert property ($rose(tx_run_q[0]) && !srst_q |-> ##[0:16] (tx_fetch_valid && tx_fetch_ctx == 3'h0))
        else $error("tx first fetch missing");
    AST_PTR_READ: assert property (pend_q && !write_q && tx_hit |=> hrdata == $past(tx_ptr_q[tx_idx]))
        else $error("tx pointer read wrong");
    AST_SET_ALIAS: assert property (acc_wr && rxs_hit && rx_idx == 2'h0 && hwdata[BIT_HDR] && !srst_q
        |=> rx_ctl_q[0][BIT_HDR])
        else $error("set alias failed");
    AST_CLR_ALIAS: assert property (acc_wr && rxc_hit && rx_idx == 2'h0 && hwdata[BIT_RUN]
        |=> !rx_ctl_q[0][BIT_RUN])
        else $error("clear alias failed");
    AST_RUN_SW_ONLY: assert property (!acc_wr && !srst_q |=> $stable(rx_run[0]))
        else $error("run changed by hardware");
    AST_ACTIVE_RUN: assert property (rx_ctl_q[0][BIT_ACTIVE] |-> rx_run[0])
        else $error("active without run");
    AST_SPLIT_FORCE: assert property (rx_ctl_q[0][BIT_SPLIT] |-> !rx_pack[0] && !rx_ctl_q[0][BIT_MULTI])
        else $error("split mode left pack or multi set");
    AST_CYC_START: assert property ($rose(rx_ctl_q[2][BIT_ACTIVE]) && $past(rx_ctl_q[2][BIT_CYC])
        |-> $past(cyc_start_valid && cyc_count == rx_match_q[2][MATCH_CYC_HI:MATCH_CYC_LO]))
        else $error("cycle start match ignored");
    AST_CYC_CLEAR: assert property (rx_ctl_q[2][BIT_ACTIVE] |-> !rx_ctl_q[2][BIT_CYC])
        else $error("start on cycle not cleared");
    AST_RSVD_ZERO: assert property (rx_ctl_q[1][26:16] == 11'h0)
        else $error("reserved bits set");
    AST_HDR_PUSH: assert property (state_q == IDC_RX_IDLE && accept && rx_first && |rx_take
        |-> push_v == hdr_sel)
        else $error("header handling wrong");
    AST_TRAILER: assert property (state_q == IDC_RX_PAY && accept && rx_last && keep
        |=> state_q == IDC_RX_TRAIL ##1 state_q == IDC_RX_IDLE || state_q == IDC_RX_TRAIL)
        else $error("trailer not emitted");
endmodule
`default_nettype wire

// ===== hw/idc_pkg.sv
// Shared constants of the isochronous DMA context register slice.
// Assumes a 4 KB register window; address bits above 11 are not decoded.
package idc_pkg;
    // ----------------------------------------
    // Geometry
    // ----------------------------------------
    localparam int unsigned NTX        = 8;
    localparam int unsigned NRX        = 4;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned BUF_WORDS  = 16;
    // ----------------------------------------
    // Register offsets and strides (log2 bytes)
    // ----------------------------------------
    localparam logic [11:0] TX_PTR_BASE   = 12'h20c;
    localparam int unsigned TX_STRIDE_LG  = 4;
    localparam logic [11:0] RX_SET_BASE   = 12'h400;
    localparam logic [11:0] RX_CLR_BASE   = 12'h404;
    localparam logic [11:0] RX_MATCH_BASE = 12'h410;
    localparam int unsigned RX_STRIDE_LG  = 5;
    localparam logic [11:0] TX_START_BASE = 12'h600;
    localparam logic [11:0] TX_RUN_OFF    = 12'h480;
    localparam logic [11:0] CHMASK_HI_OFF = 12'h070;
    localparam logic [11:0] CHMASK_LO_OFF = 12'h078;
    localparam logic [11:0] SOFT_RST_OFF  = 12'h050;
    // ----------------------------------------
    // Receive control fields
    // ----------------------------------------
    localparam int unsigned BIT_PACK   = 31;
    localparam int unsigned BIT_HDR    = 30;
    localparam int unsigned BIT_CYC    = 29;
    localparam int unsigned BIT_MULTI  = 28;
    localparam int unsigned BIT_SPLIT  = 27;
    localparam int unsigned BIT_RUN    = 15;
    localparam int unsigned BIT_ACTIVE = 10;
    localparam logic [31:0] RX_SW_MASK = 32'hf800_8000;
    localparam logic [31:0] RX_MATCH_MASK = 32'h01ff_f03f;
    localparam int unsigned MATCH_CYC_HI = 24;
    localparam int unsigned MATCH_CYC_LO = 12;
    localparam int unsigned CHAN_HI    = 13;
    localparam int unsigned CHAN_LO    = 8;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [31:0] RX_CTL_RST = 32'h0000_0000;
    localparam logic [31:0] TX_PTR_RST = 32'h0000_0000;
    localparam logic [31:0] REG_RST    = 32'h0000_0000;

    typedef enum logic [1:0] {
        IDC_RX_IDLE  = 2'b00,
        IDC_RX_PAY   = 2'b01,
        IDC_RX_TRAIL = 2'b10
    } idc_rx_state_e;
endpackage

// ===== tb/idc_host_model.sv
// Host memory model: accepts descriptor fetches and buffer words.
// Assumes the block's clock and reset; stalls in a fixed rolling pattern.
`timescale 1ns/1ps
`default_nettype none
module idc_host_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    output logic      tx_fetch_ready,
    output logic      mem_ready
);
    logic [3:0] tick_q;
    // Mixed prompt and slow acceptance, so back-pressure is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) tick_q <= 4'h0;
        else tick_q <= tick_q + 4'h1;
    end
    assign tx_fetch_ready = tick_q[1] & tick_q[0];
    assign mem_ready      = tick_q[2] | tick_q[0];
endmodule
`default_nettype wire

// ===== tb/idc_iso_dma_regs_test.sv
// Self-checking bench for the isochronous DMA context registers.
// Assumes the host model answers the fetch and buffer streams.
`timescale 1ns/1ps
`default_nettype none
module idc_iso_dma_regs_test;
    import idc_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_ready, rx_valid, rx_first, rx_last, mem_buf_end;
    logic tx_fetch_valid, tx_fetch_ready, tx_ptr_upd_valid, cyc_start_valid, mem_valid, mem_ready;
    logic [31:0] haddr, hwdata, hrdata, tx_fetch_addr, tx_ptr_upd_value, rx_data, mem_data, rnd, v, rd, h, p1, p2;
    logic [1:0]  htrans, mem_ctx;
    logic [2:0]  hsize, tx_fetch_ctx, tx_ptr_upd_ctx, cyc_seconds_low;
    logic [12:0] cyc_count, cc;
    logic [15:0] rx_status;
    logic [3:0]  rx_active;
    logic [63:0] mq[$], fq[$];
    int          err_total, compares;
    idc_iso_dma_regs uut (.hready(hreadyout), .*);
    idc_host_model host (.*);
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        do @(posedge hclk); while (!hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
        rd = hrdata;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk({hresp, rd}, {1'b0, e});
    endtask
    task send(input logic [31:0] d, input logic f, input logic l);
        rx_valid <= 1'b1;
        rx_data <= d;
        rx_first <= f;
        rx_last <= l;
        do @(posedge hclk); while (!rx_ready);
    endtask
    task cyc(input logic [12:0] c);
        cyc_start_valid <= 1'b1;
        cyc_count <= c;
        @(posedge hclk);
        cyc_start_valid <= 1'b0;
    endtask
    // Scoreboard: oldest note against each accepted output word
    always @(posedge hclk) begin
        if (hresetn && mem_valid && mem_ready)
            chk({mem_buf_end, mem_ctx, mem_data}, mq.size() ? mq.pop_front() : 'x);
        if (hresetn && tx_fetch_valid && tx_fetch_ready)
            chk({tx_fetch_ctx, tx_fetch_addr}, fq.size() ? fq.pop_front() : 'x);
    end
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        conclude;
    end
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, rx_valid, rx_first, rx_last, rx_data, rx_status} = '0;
        {tx_ptr_upd_valid, tx_ptr_upd_ctx, tx_ptr_upd_value, cyc_start_valid, cyc_count} = '0;
        hsize = 3'h2;
        cyc_seconds_low = 3'h5;
        hresetn = 1'b0;
        rnd = 32'h0001_0e62;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int n = 0; n < 4; n++) begin
            rdc(RX_SET_BASE + 12'(32 * n), RX_CTL_RST);
            rdc(RX_CLR_BASE + 12'(32 * n), RX_CTL_RST);
        end
        rdc(12'h100, 32'h0);
        ahb(1'b1, 12'h420, 32'hd7ff_0000);
        rdc(12'h424, 32'hd000_0000);
        ahb(1'b1, 12'h424, 32'h4000_0000);
        rdc(12'h420, 32'h9000_0000);
        ahb(1'b1, 12'h420, 32'h0800_0000);
        rdc(12'h420, 32'h0800_0000);
        ahb(1'b1, 12'h424, 32'hffff_ffff);
        rdc(12'h420, 32'h0);
        $display("test control aliases done");
        for (int n = 0; n < 8; n += 7) begin
            rnd = nx(rnd);
            v = rnd & 32'hffff_fff0;
            fq.push_back({29'h0, 3'(n), v});
            ahb(1'b1, TX_START_BASE + 12'(16 * n), v);
            ahb(1'b1, TX_RUN_OFF, 32'(1 << n));
            rdc(TX_PTR_BASE + 12'(16 * n), v);
            ahb(1'b1, TX_PTR_BASE + 12'(16 * n), ~v);
            tx_ptr_upd_valid <= 1'b1;
            tx_ptr_upd_ctx <= 3'(n);
            tx_ptr_upd_value <= v + 32'h10;
            @(posedge hclk);
            tx_ptr_upd_valid <= 1'b0;
            rdc(TX_PTR_BASE + 12'(16 * n), v + 32'h10);
        end
        $display("test transmit pointers done");
        rnd = nx(rnd);
        cc = rnd[12:0];
        ahb(1'b1, CHMASK_LO_OFF, 32'h0000_0020);
        cyc(cc);
        // Last packet: match names channel 6, only the mask admits channel 5
        for (int m = 0; m < 4; m++) begin
            v = (m == 0) ? 32'h4000_8000 : (m == 1) ? 32'h8000_8000 : (m == 2) ? 32'h0000_8000 : 32'h9000_8000;
            ahb(1'b1, RX_CLR_BASE, 32'h0000_8000);
            ahb(1'b1, RX_CLR_BASE, 32'hf800_0000);
            ahb(1'b1, RX_MATCH_BASE, (m == 3) ? 32'h6 : 32'h5);
            ahb(1'b1, RX_SET_BASE, v);
            rdc(RX_SET_BASE, v | 32'h400);
            chk(rx_active, 4'h1);
            rnd = nx(rnd);
            h = (rnd & 32'hffff_c0ff) | 32'h0000_0500;
            p1 = nx(rnd);
            p2 = nx(p1);
            rx_status <= rnd[15:0];
            if (m == 0) mq.push_back({32'h0, h});
            mq.push_back({32'h0, p1});
            mq.push_back({29'h0, m == 2, 2'h0, p2});
            if (m == 0) mq.push_back({30'h1, 2'h0, rnd[15:0], cyc_seconds_low, cc});
            send(h, 1'b1, 1'b0);
            send(p1, 1'b0, 1'b0);
            send(p2, 1'b0, 1'b1);
            rx_valid <= 1'b0;
        end
        $display("test receive packets done");
        ahb(1'b1, RX_CLR_BASE, 32'h0000_8000);
        rnd = nx(rnd);
        cc = rnd[12:0];
        ahb(1'b1, 12'h450, {7'h0, cc, 12'h0});
        ahb(1'b1, 12'h440, 32'h2000_8000);
        cyc(cc + 13'h1);
        rdc(12'h440, 32'h2000_8000);
        cyc(cc);
        rdc(12'h440, 32'h0000_8400);
        chk(rx_active, 4'h4);
        ahb(1'b1, SOFT_RST_OFF, 32'h1);
        rdc(12'h440, 32'h0);
        $display("test cycle start done");
        repeat (60) @(posedge hclk);
        chk(mq.size() + fq.size(), 0);
        conclude;
    end
endmodule
`default_nettype wire
